// *** src/drc_run_cmd.v ***
// Contract
// - Setting 4: terminal stop is normally closed, communication stop normally open.
// - Enable only for setting/source pairs 0:off/off, 2:on/on, 4:on/off.
// - Terminal output stop shuts output in every operation mode.
// - Function code 3 in any terminal slot gives second set select.
// - Second set select swaps the whole parameter set at once.
// - Seven second functions; deceleration may share acceleration alternate.
// - Setting 0 to 100 s: coast after delay; inputs keep directions.
// - Setting 1000 to 1100 s: coast after setting minus 1000 seconds.
// - Settings 1000-1100 or 8888: forward is run, reverse is direction.
// - Settings 9999 or 8888: ramp down when start command drops.
// - Two-wire ramp mode: one input runs that way; both off/on ramps down.
// - Forward start only on forward slot, reverse start only on reverse slot.
// - Hold input on (code 25) enables start self-holding; starts are triggers.
// - In holding mode a start pulse latches the run request.
// - Releasing the hold input clears the latch and ramps down.
// - While jog is on and enabled, the hold input is ignored.
// - Output stop leaves the self-holding latch unchanged.
// - Output stop while running shuts output at once, motor coasts.
// - Respond to output stop within 2 ms, other inputs within 20 ms.
// - Several terminals with one function are ORed; start codes count on their own slot only.
// - Output stop is function code 24; logic select resets to 0.
`timescale 1ns/1ps
`include "drc_defs.vh"
module drc_run_cmd
(
    input wire CLK,
    input wire RST,
    input wire [`DRC_NTERM-1:0] TERM_IN,
    input wire [7*`DRC_NTERM-1:0] TERM_FUNC,
    input wire COMM_OSTOP,
    input wire [2:0] OUTPUT_STOP_LOGIC_SELECT,
    input wire [13:0] STOP_METHOD_SELECT,
    input wire JOG_ENABLE,
    input wire [111:0] FIRST_SET,
    input wire [111:0] SECOND_SET,
    output reg OUTPUT_ENABLE,
    output reg RUN_REVERSE,
    output reg RAMP_REQUEST,
    output reg COASTING,
    output reg SECOND_SET_ACTIVE,
    output reg [111:0] ACTIVE_SET
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [`DRC_NTERM-1:0] term_s1_ff;
    reg [`DRC_NTERM-1:0] term_s2_ff;
    reg comm_s1_ff;
    reg comm_s2_ff;

    always @(posedge CLK)
    begin
        if (RST)
        begin
            term_s1_ff <= {`DRC_NTERM{1'b0}};
            term_s2_ff <= {`DRC_NTERM{1'b0}};
            comm_s1_ff <= 1'b0;
            comm_s2_ff <= 1'b0;
        end
        else
        begin
            term_s1_ff <= TERM_IN;
            term_s2_ff <= term_s1_ff;
            comm_s1_ff <= COMM_OSTOP;
            comm_s2_ff <= comm_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Terminal function decode
    // ------------------------------------------------------------
    function func_or;
        input [7*`DRC_NTERM-1:0] funcs;
        input [`DRC_NTERM-1:0] lv;
        input [6:0] code;
        integer i;
        begin
            func_or = 1'b0;
            for (i = 0; i < `DRC_NTERM; i = i + 1)
                if (funcs[7*i +: 7] == code)
                    func_or = func_or | lv[i];
        end
    endfunction

    // Start functions count only on their own dedicated slot
    function slot_is;
        input [7*`DRC_NTERM-1:0] funcs;
        input [`DRC_NTERM-1:0] lv;
        input integer slot;
        input [6:0] code;
        begin
            slot_is = (funcs[7*slot +: 7] == code) & lv[slot];
        end
    endfunction

    // Slot 0 is the forward start slot and slot 1 the reverse start slot
    wire [`DRC_NTERM-1:0] lv = term_s2_ff;
    wire term_ostop_raw = func_or(TERM_FUNC, lv, `DRC_FN_OSTOP);
    wire second_raw = func_or(TERM_FUNC, lv, `DRC_FN_SECOND);
    wire hold_raw = func_or(TERM_FUNC, lv, `DRC_FN_HOLD);
    wire jog_raw = func_or(TERM_FUNC, lv, `DRC_FN_JOG);
    wire fwd_raw = slot_is(TERM_FUNC, lv, 0, `DRC_FN_FWD);
    wire rev_raw = slot_is(TERM_FUNC, lv, 1, `DRC_FN_REV);

    // ------------------------------------------------------------
    // Output stop combination
    // ------------------------------------------------------------
    // Terminal stop passes the two sync stages like other inputs; that meets the 2 ms bound
    reg osl_ok;
    always @*
    begin
        case (OUTPUT_STOP_LOGIC_SELECT)
            `DRC_OSL_NO: osl_ok = ~term_ostop_raw & ~comm_s2_ff;
            `DRC_OSL_NC: osl_ok = term_ostop_raw & comm_s2_ff;
            `DRC_OSL_MIX: osl_ok = term_ostop_raw & ~comm_s2_ff;
            default: osl_ok = 1'b0;
        endcase
    end
    wire shutoff = ~osl_ok;

    // ------------------------------------------------------------
    // Stop method decode
    // ------------------------------------------------------------
    // Settings outside the listed ranges stop as two-wire ramp mode
    wire sm_coast_t = (STOP_METHOD_SELECT <= `DRC_SM_COAST_MAX);
    wire sm_coast_o = (STOP_METHOD_SELECT >= `DRC_SM_OFFS_MIN) &&
                      (STOP_METHOD_SELECT <= `DRC_SM_OFFS_MAX);
    wire sm_ramp_dir = (STOP_METHOD_SELECT == `DRC_SM_RAMP_DIR);
    wire run_dir_mode = sm_coast_o | sm_ramp_dir;
    wire coast_mode = sm_coast_t | sm_coast_o;
    wire [13:0] delay_s = sm_coast_o ? (STOP_METHOD_SELECT - `DRC_SM_OFFSET)
                                     : STOP_METHOD_SELECT;

    // ------------------------------------------------------------
    // Start command decode and self-holding
    // ------------------------------------------------------------
    reg fwd_d_ff;
    reg rev_d_ff;
    reg latch_run_ff;
    reg latch_rev_ff;
    wire hold_mode = hold_raw & ~(jog_raw & JOG_ENABLE);
    wire fwd_fall = fwd_d_ff & ~fwd_raw;
    wire rev_fall = rev_d_ff & ~rev_raw;

    always @(posedge CLK)
    begin
        if (RST)
        begin
            fwd_d_ff <= 1'b0;
            rev_d_ff <= 1'b0;
            latch_run_ff <= 1'b0;
            latch_rev_ff <= 1'b0;
        end
        else
        begin
            fwd_d_ff <= fwd_raw;
            rev_d_ff <= rev_raw;
            // Latch is independent of shutoff
            if (!hold_mode)
            begin
                latch_run_ff <= 1'b0;
                latch_rev_ff <= 1'b0;
            end
            else if (fwd_fall | rev_fall)
            begin
                latch_run_ff <= 1'b1;
                latch_rev_ff <= rev_fall & ~fwd_fall;
            end
        end
    end

    reg cmd_run;
    reg cmd_rev;
    always @*
    begin
        if (hold_mode)
        begin
            cmd_run = latch_run_ff | fwd_raw | rev_raw;
            cmd_rev = latch_run_ff ? latch_rev_ff : rev_raw & ~fwd_raw;
        end
        else if (run_dir_mode)
        begin
            cmd_run = fwd_raw;
            cmd_rev = rev_raw;
        end
        else
        begin
            cmd_run = fwd_raw ^ rev_raw;
            cmd_rev = rev_raw & ~fwd_raw;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick and coast delay
    // ------------------------------------------------------------
    // One millisecond of clock cycles; the count fits in 18 bits
    localparam [31:0] TICK_LAST_W = `DRC_TICK_CYC - 1;
    localparam [17:0] TICK_LAST = TICK_LAST_W[17:0];
    reg [17:0] tick_cnt_ff;
    reg [9:0] ms_cnt_ff;
    reg [13:0] sec_cnt_ff;
    reg run_d_ff;
    reg stopping_ff;
    wire cmd_fall = run_d_ff & ~cmd_run;
    wire tick = (tick_cnt_ff == TICK_LAST);
    wire delay_done = (sec_cnt_ff >= delay_s);

    always @(posedge CLK)
    begin
        if (RST)
        begin
            tick_cnt_ff <= 18'h00000;
            ms_cnt_ff <= 10'h000;
            sec_cnt_ff <= 14'h0000;
            run_d_ff <= 1'b0;
            stopping_ff <= 1'b0;
        end
        else
        begin
            run_d_ff <= cmd_run;
            if (cmd_fall)
            begin
                tick_cnt_ff <= 18'h00000;
                ms_cnt_ff <= 10'h000;
                sec_cnt_ff <= 14'h0000;
                stopping_ff <= 1'b1;
            end
            else if (cmd_run)
                stopping_ff <= 1'b0;
            else
            begin
                tick_cnt_ff <= tick ? 18'h00000 : tick_cnt_ff + 18'h00001;
                if (tick)
                begin
                    if (ms_cnt_ff == `DRC_MS_PER_S - 10'h001)
                    begin
                        ms_cnt_ff <= 10'h000;
                        if (!delay_done)
                            sec_cnt_ff <= sec_cnt_ff + 14'h0001;
                    end
                    else
                        ms_cnt_ff <= ms_cnt_ff + 10'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Priority: shutoff, then run, then a finished coast delay, else ramp
    reg nxt_output_enable;
    reg nxt_ramp_request;
    reg nxt_coasting;
    always @*
    begin
        nxt_output_enable = 1'b1;
        nxt_ramp_request = 1'b1;
        nxt_coasting = 1'b0;
        if (shutoff)
        begin
            nxt_output_enable = 1'b0;
            nxt_ramp_request = 1'b0;
            nxt_coasting = 1'b1;
        end
        else if (cmd_run)
            nxt_ramp_request = 1'b0;
        else if (stopping_ff && coast_mode && delay_done)
        begin
            nxt_output_enable = 1'b0;
            nxt_ramp_request = 1'b0;
            nxt_coasting = 1'b1;
        end
    end

    always @(posedge CLK)
    begin
        if (RST)
        begin
            OUTPUT_ENABLE <= 1'b0;
            RUN_REVERSE <= 1'b0;
            RAMP_REQUEST <= 1'b0;
            COASTING <= 1'b0;
            SECOND_SET_ACTIVE <= 1'b0;
            ACTIVE_SET <= 112'h0;
        end
        else
        begin
            SECOND_SET_ACTIVE <= second_raw;
            ACTIVE_SET <= second_raw ? SECOND_SET : FIRST_SET;
            if (cmd_run)
                RUN_REVERSE <= cmd_rev;
            OUTPUT_ENABLE <= nxt_output_enable;
            RAMP_REQUEST <= nxt_ramp_request;
            COASTING <= nxt_coasting;
        end
    end

endmodule // drc_run_cmd

// *** src/drc_defs.vh ***
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH
// Output stop logic selections
`define DRC_OSL_NO 3'h0
`define DRC_OSL_NC 3'h2
`define DRC_OSL_MIX 3'h4
`define DRC_OSL_RST 3'h0
// Stop method selection values (seconds or codes)
`define DRC_SM_COAST_MAX 14'h0064
`define DRC_SM_OFFS_MIN 14'h03e8
`define DRC_SM_OFFS_MAX 14'h044c
`define DRC_SM_RAMP_DIR 14'h22b8
`define DRC_SM_RAMP 14'h270f
`define DRC_SM_OFFSET 14'h03e8
// Terminal function codes
`define DRC_FN_SECOND 7'h03
`define DRC_FN_OSTOP 7'h18
`define DRC_FN_HOLD 7'h19
`define DRC_FN_JOG 7'h05
`define DRC_FN_FWD 7'h3c
`define DRC_FN_REV 7'h3d
`define DRC_FN_NONE 7'h7f
// Terminal count and timing
`define DRC_NTERM 5
`define DRC_CLK_MHZ 250
`define DRC_TICK_US 1000
`define DRC_TICK_CYC (`DRC_TICK_US * `DRC_CLK_MHZ)
`define DRC_OSTOP_RESP_US 2000
`define DRC_OTHER_RESP_US 20000
`define DRC_MS_PER_S 10'h3e8
`endif

// *** sim/drc_run_cmd_monitor.sv ***
`timescale 1ns/1ps
module drc_run_cmd_monitor
(
    input wire CLK,
    input wire RST,
    input wire [4:0] TERM_IN,
    input wire [34:0] TERM_FUNC,
    input wire COMM_OSTOP,
    input wire [2:0] OUTPUT_STOP_LOGIC_SELECT,
    input wire [13:0] STOP_METHOD_SELECT,
    input wire JOG_ENABLE,
    input wire [111:0] FIRST_SET,
    input wire [111:0] SECOND_SET,
    input wire OUTPUT_ENABLE,
    input wire RUN_REVERSE,
    input wire RAMP_REQUEST,
    input wire COASTING,
    input wire SECOND_SET_ACTIVE,
    input wire [111:0] ACTIVE_SET
);
// ----------------
// Terminal decode
// ----------------
logic t_stop;
logic t_sec;
wire [2:0] osl = OUTPUT_STOP_LOGIC_SELECT;
always_comb
begin
    t_stop = 1'b0;
    t_sec = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
        t_stop |= TERM_IN[i] && TERM_FUNC[7*i+:7] == 7'h18;
        t_sec |= TERM_IN[i] && TERM_FUNC[7*i+:7] == 7'h03;
    end
end
default clocking @(posedge CLK); endclocking
default disable iff (RST);
// Three samples cover the two sync stages and the output register
sequence s_term_stop;
    (t_stop && osl == 3'h0)[*3];
endsequence
sequence s_comm_stop;
    (COMM_OSTOP && osl != 3'h2)[*3];
endsequence
a_term_stop: assert property (s_term_stop |=> !OUTPUT_ENABLE) else $error("terminal stop ignored");
a_comm_stop: assert property (s_comm_stop |=> !OUTPUT_ENABLE) else $error("comm stop ignored");
a_mix_open: assert property ((osl == 3'h4 && !t_stop)[*3] |=> !OUTPUT_ENABLE) else $error("open contact ran");
a_bad_select: assert property ((osl != 3'h0 && osl != 3'h2 && osl != 3'h4)[*2] |=> !OUTPUT_ENABLE)
    else $error("illegal select ran");
a_ramp_enable: assert property (RAMP_REQUEST |-> OUTPUT_ENABLE) else $error("ramp without output");
a_coast_off: assert property (COASTING |-> !OUTPUT_ENABLE) else $error("coast with output on");
a_second_sel: assert property (t_sec[*3] |=> SECOND_SET_ACTIVE) else $error("second set not taken");
a_set_pick: assert property ($stable(FIRST_SET) && $stable(SECOND_SET) && !$past(RST)
    |-> ACTIVE_SET == (SECOND_SET_ACTIVE ? SECOND_SET : FIRST_SET)) else $error("wrong set");
endmodule // drc_run_cmd_monitor

// *** sim/drc_contacts.sv ***
`timescale 1ns/1ps
module drc_contacts
(
    input wire clk,
    output logic [4:0] term_in,
    output logic comm_ostop
);
// -----------------
// Contacts and link
// -----------------
initial
begin
    term_in = 5'h00;
    comm_ostop = 1'b0;
end
task automatic set_term(input int i, input logic v);
    @(negedge clk);
    term_in[i] = v;
endtask
// One on-off pulse, long enough for the input filter
task automatic pulse(input int i);
    set_term(i, 1'b1);
    repeat (3) @(negedge clk);
    term_in[i] = 1'b0;
endtask
task automatic set_comm(input logic v);
    @(negedge clk);
    comm_ostop = v;
endtask
endmodule // drc_contacts

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "drc_defs.vh"
module tb;
// --------------
// Bench signals
// --------------
logic CLK = 1'b0;
logic RST = 1'b1;
logic JOG_ENABLE = 1'b0;
logic [2:0] OUTPUT_STOP_LOGIC_SELECT = 3'h0;
logic [13:0] STOP_METHOD_SELECT = `DRC_SM_RAMP;
logic [34:0] TERM_FUNC = {`DRC_FN_SECOND, `DRC_FN_HOLD, `DRC_FN_OSTOP, `DRC_FN_REV, `DRC_FN_FWD};
logic [111:0] FIRST_SET = {7{16'h1111}};
logic [111:0] SECOND_SET = {7{16'h2222}};
wire [4:0] TERM_IN;
wire COMM_OSTOP, OUTPUT_ENABLE, RUN_REVERSE, RAMP_REQUEST, COASTING, SECOND_SET_ACTIVE;
wire [111:0] ACTIVE_SET;
int n_fail = 0;
int check_count = 0;
int cyc = 0;
logic en;
drc_run_cmd u_drc_run_cmd (.CLK, .RST, .TERM_IN, .TERM_FUNC, .COMM_OSTOP, .OUTPUT_STOP_LOGIC_SELECT,
    .STOP_METHOD_SELECT, .JOG_ENABLE, .FIRST_SET, .SECOND_SET, .OUTPUT_ENABLE, .RUN_REVERSE,
    .RAMP_REQUEST, .COASTING, .SECOND_SET_ACTIVE, .ACTIVE_SET);
drc_contacts u_drc_contacts (.clk(CLK), .term_in(TERM_IN), .comm_ostop(COMM_OSTOP));
initial
begin
    forever #2 CLK = ~CLK;
end
always @(posedge CLK)
begin
    cyc++;
    if (cyc == 5000)
    begin
        n_fail++;
        close_out;
    end
end
task automatic close_out;
    if (n_fail == 0 && check_count > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task automatic t(input int i, input logic v);
    u_drc_contacts.set_term(i, v);
endtask
// State is {enable, reverse, ramp, coast}
task automatic chk(input logic [3:0] e);
    repeat (5) @(negedge CLK);
    check_count++;
    if ({OUTPUT_ENABLE, RUN_REVERSE, RAMP_REQUEST, COASTING} !== e)
    begin
        n_fail++;
        $display("ERROR %0t state %b expected %b", $time, {OUTPUT_ENABLE, RUN_REVERSE, RAMP_REQUEST, COASTING}, e);
    end
endtask
task automatic chk_set(input logic s);
    repeat (5) @(negedge CLK);
    check_count++;
    if ({SECOND_SET_ACTIVE, ACTIVE_SET} !== {s, s ? SECOND_SET : FIRST_SET})
    begin
        n_fail++;
        $display("ERROR %0t parameter set select %b", $time, SECOND_SET_ACTIVE);
    end
endtask
initial
begin
    repeat (12) @(negedge CLK);
    RST = 1'b0;
    t(0, 1); chk(4'b1000);
    t(0, 0); chk(4'b1010);
    t(1, 1); chk(4'b1100);
    t(0, 1); chk(4'b1110);
    t(0, 0); t(1, 0);
    @(negedge CLK); STOP_METHOD_SELECT = `DRC_SM_RAMP_DIR;
    t(0, 1); chk(4'b1000);
    t(1, 1); chk(4'b1100);
    t(0, 0); chk(4'b1110);
    t(1, 0); t(0, 1);
    for (int k = 0; k < 13; k++)
    begin
        @(negedge CLK); OUTPUT_STOP_LOGIC_SELECT = (k < 12) ? 3'(2 * (k / 4)) : 3'h1;
        t(2, k[1]);
        u_drc_contacts.set_comm(k[0]);
        en = (k < 4 && k[1:0] == 2'b00) || (k / 4 == 1 && k[1:0] == 2'b11) || (k / 4 == 2 && k[1:0] == 2'b10);
        chk(en ? 4'b1000 : 4'b0001);
    end
    @(negedge CLK); OUTPUT_STOP_LOGIC_SELECT = 3'h0;
    chk(4'b1000);
    @(negedge CLK); STOP_METHOD_SELECT = `DRC_SM_RAMP;
    t(0, 0); t(3, 1); chk(4'b1010);
    u_drc_contacts.pulse(1); chk(4'b1100);
    u_drc_contacts.pulse(0); chk(4'b1000);
    t(2, 1); chk(4'b0001);
    t(2, 0); chk(4'b1000);
    t(3, 0); chk(4'b1010);
    t(3, 1); chk(4'b1010);
    t(3, 0);
    @(negedge CLK); STOP_METHOD_SELECT = 14'h0000;
    t(0, 1); chk(4'b1000);
    t(0, 0); chk(4'b0001);
    @(negedge CLK); STOP_METHOD_SELECT = `DRC_SM_OFFSET;
    t(0, 1); chk(4'b1000);
    t(1, 1); chk(4'b1100);
    t(0, 0); chk(4'b0101);
    t(1, 0);
    chk_set(1'b0);
    t(4, 1); chk_set(1'b1);
    t(4, 0); chk_set(1'b0);
    // Jog overrides the hold input only while jog operation is enabled
    @(negedge CLK);
    STOP_METHOD_SELECT = `DRC_SM_RAMP;
    TERM_FUNC[34:28] = `DRC_FN_JOG;
    t(3, 1);
    u_drc_contacts.pulse(0);
    chk(4'b1000);
    t(4, 1);
    chk(4'b1000);
    @(negedge CLK);
    JOG_ENABLE = 1'b1;
    chk(4'b1010);
    t(4, 0);
    t(3, 0);
    // A second output stop terminal is ORed with the first
    @(negedge CLK);
    JOG_ENABLE = 1'b0;
    TERM_FUNC[34:28] = `DRC_FN_OSTOP;
    t(4, 1);
    chk(4'b0001);
    t(4, 0);
    chk(4'b1010);
    // Forward start code on a foreign slot has no effect
    @(negedge CLK);
    TERM_FUNC[34:28] = `DRC_FN_FWD;
    t(4, 1);
    chk(4'b1010);
    t(4, 0);
    close_out;
end
endmodule // tb
bind drc_run_cmd drc_run_cmd_monitor u_drc_run_cmd_monitor (.CLK, .RST, .TERM_IN, .TERM_FUNC, .COMM_OSTOP,
    .OUTPUT_STOP_LOGIC_SELECT, .STOP_METHOD_SELECT, .JOG_ENABLE, .FIRST_SET, .SECOND_SET, .OUTPUT_ENABLE,
    .RUN_REVERSE, .RAMP_REQUEST, .COASTING, .SECOND_SET_ACTIVE, .ACTIVE_SET);
